// ===== rtl/gpc_top.v
// Geared pulse counter top: two counters, gear, compare, AXI4-Lite slave.
// Assumes terminal inputs synchronous to clk_i and pulses far slower
// than the gear update period of about 50 clocks.
`timescale 1ns/1ps
`include "gpc_defines.vh"
module gpc_top (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        counter_in_i,
  input  wire        counter_reset_i,
  input  wire        counter2_in_i,
  output reg         target_reached_o,
  output wire [1:0]  stop_action_o,
  output wire        retain_count_o,
  output wire        irq_o,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [31:0] target_reg;
  reg  [31:0] ceil_reg;
  reg  [15:0] mult_reg;
  reg  [15:0] div_reg;
  reg  [8:0]  ctrl_reg;
  reg  [2:0]  stat_reg;
  reg  [2:0]  mask_reg;
  reg  [1:0]  wrap_wait_reg;
  reg         at_ceil_d_reg;

  wire [31:0] raw_total;
  wire [31:0] geared;
  wire [15:0] cnt2;
  wire        gear_done;
  wire        cnt2_wrap;
  wire        at_ceil;
  wire        at_target;
  wire        method_wrap;
  wire        wrap_now;
  wire        clear1;
  wire        hold1;

  // ****************************************
  // Counter 1 with gear
  // ****************************************
  // Both limits compare the geared value; a stale pass after a clear is
  // kept out by the blanking count below
  assign method_wrap = ctrl_reg[`GPC_CTRL_METHOD];
  assign at_ceil     = (wrap_wait_reg == 2'h0) && (geared >= ceil_reg);
  assign at_target   = (wrap_wait_reg == 2'h0) && (geared >= target_reg);
  assign wrap_now    = at_ceil & method_wrap;
  assign clear1      = counter_reset_i | wrap_now;
  assign hold1       = at_ceil & ~method_wrap;

  gpc_edge_cnt #(
    .W (32)
  ) u_cnt1 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (counter_in_i),
    .clear_i   (clear1),
    .hold_i    (hold1),
    .count_o   (raw_total),
    .wrap_o    ()
  );

  gpc_gear u_gear (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .raw_i     (raw_total),
    .mult_i    (mult_reg),
    .div_i     (div_reg),
    .geared_o  (geared),
    .done_o    (gear_done)
  );

  // ****************************************
  // Counter 2, no gear
  // ****************************************
  // No clear terminal and no ceiling here: it simply wraps at 16 bits,
  // and the wrap is reported as a status event
  gpc_edge_cnt #(
    .W (16)
  ) u_cnt2 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (counter2_in_i),
    .clear_i   (1'b0),
    .hold_i    (1'b0),
    .count_o   (cnt2),
    .wrap_o    (cnt2_wrap)
  );

  // After a clear the gear result is stale for up to two passes;
  // comparisons are blanked until a pass that began after the clear ends.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wrap_wait_reg    <= 2'h0;
      target_reached_o <= 1'b0;
      at_ceil_d_reg    <= 1'b0;
    end else begin
      if (clear1) begin
        wrap_wait_reg <= `GPC_BLANK_PASS;
      end else if (gear_done && wrap_wait_reg != 2'h0) begin
        wrap_wait_reg <= wrap_wait_reg - 2'h1;
      end
      if (clear1) begin
        target_reached_o <= 1'b0;
      end else if (wrap_wait_reg == 2'h0) begin
        target_reached_o <= at_target;
      end
      at_ceil_d_reg <= at_ceil;
    end
  end

  // The action code is shown only while the target flag stands, so the
  // drive sees no stop request after a clear
  assign stop_action_o  = target_reached_o ?
                          ctrl_reg[`GPC_CTRL_ACT_HI:`GPC_CTRL_ACT_LO] : 2'h0;
  assign retain_count_o = ctrl_reg[`GPC_CTRL_KEEP];

  // ****************************************
  // Interrupt status
  // ****************************************
  wire [2:0] ev;
  wire [2:0] w1c;

  assign ev[`GPC_ST_TARGET] = at_target & ~target_reached_o & ~clear1;
  assign ev[`GPC_ST_CEIL]   = at_ceil & ~at_ceil_d_reg;
  assign ev[`GPC_ST_CNT2]   = cnt2_wrap;
  assign irq_o              = |(stat_reg & mask_reg);

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  wire       wr_fire;
  wire       wr_hit;
  wire [31:0] wmask;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                  {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  // Unmapped or unaligned words answer with an error and change nothing
  assign wr_hit = (aw_addr_reg[7:2] <= `GPC_LAST_IDX) && (aw_addr_reg[1:0] == 2'h0);
  assign w1c    = (wr_fire && aw_addr_reg == `GPC_OFF_STAT) ?
                  (w_data_reg[2:0] & wmask[2:0]) : 3'h0;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  wire [31:0] new_target;
  wire [31:0] new_ceil;
  wire [31:0] new_mult;
  wire [31:0] new_div;
  wire [31:0] new_ctrl;
  wire [31:0] new_mask;

  assign new_target = merge(target_reg, w_data_reg, wmask);
  assign new_ceil   = merge(ceil_reg, w_data_reg, wmask);
  assign new_mult   = merge({16'h0, mult_reg}, w_data_reg, wmask);
  assign new_div    = merge({16'h0, div_reg}, w_data_reg, wmask);
  assign new_ctrl   = merge({23'h0, ctrl_reg}, w_data_reg, wmask);
  assign new_mask   = merge({29'h0, mask_reg}, w_data_reg, wmask);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `GPC_RESP_OKAY;
      target_reg   <= `GPC_RST_TARGET;
      ceil_reg     <= `GPC_RST_CEIL;
      mult_reg     <= `GPC_RST_MULT;
      div_reg      <= `GPC_RST_DIV;
      ctrl_reg     <= `GPC_RST_CTRL;
      mask_reg     <= `GPC_RST_MASK;
      stat_reg     <= `GPC_RST_STAT;
    end else begin
      // Set wins over a same-cycle write-one clear
      stat_reg <= (stat_reg & ~w1c) | ev;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
        // Zero is out of range for these settings; such a write is dropped
        case (aw_addr_reg)
          `GPC_OFF_TARGET: begin
            if (new_target != 32'h0) target_reg <= new_target;
          end
          `GPC_OFF_CEIL: begin
            if (new_ceil != 32'h0) ceil_reg <= new_ceil;
          end
          `GPC_OFF_MULT: begin
            if (new_mult[15:0] != 16'h0) mult_reg <= new_mult[15:0];
          end
          `GPC_OFF_DIV: begin
            if (new_div[15:0] != 16'h0) div_reg <= new_div[15:0];
          end
          `GPC_OFF_CTRL: begin
            // Unused control digits are kept at zero
            ctrl_reg <= new_ctrl[8:0] & `GPC_CTRL_WMASK;
          end
          `GPC_OFF_MASK: begin
            mask_reg <= new_mask[2:0];
          end
          default: begin
            // Read-only counts ignore writes
            mask_reg <= mask_reg;
          end
        endcase
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  reg [31:0] rd_mux;
  reg        rd_hit;

  // One read at a time: the answer is latched on the address edge and
  // stands until it is taken
  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `GPC_OFF_RAW:    rd_mux = raw_total;
      `GPC_OFF_GEARED: rd_mux = geared;
      `GPC_OFF_TARGET: rd_mux = target_reg;
      `GPC_OFF_CEIL:   rd_mux = ceil_reg;
      `GPC_OFF_MULT:   rd_mux = {16'h0, mult_reg};
      `GPC_OFF_DIV:    rd_mux = {16'h0, div_reg};
      `GPC_OFF_CTRL:   rd_mux = {23'h0, ctrl_reg};
      `GPC_OFF_CNT2:   rd_mux = {16'h0, cnt2};
      `GPC_OFF_STAT:   rd_mux = {29'h0, stat_reg};
      `GPC_OFF_MASK:   rd_mux = {29'h0, mask_reg};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `GPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `GPC_RESP_OKAY : `GPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/gpc_defines.vh
// Constants of the geared pulse counter: register offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
// Functional notes
// - Count input pulses into 32-bit raw total
// - Count value equals raw times numerator over denominator
// - Geared count is read-only to software
// - Flag set value reached; default 1000
// - Programmable ceiling; stop or reset there
// - Reset terminal active clears the counter
// - Compare geared value, not raw pulses
// - Second 16-bit counter without gear
// - Method 0 stops, 1 recounts from zero
// - Action digit selects drive stop kind
// - Retain digit selects power-loss save
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define GPC_OFF_RAW     8'h00
`define GPC_OFF_GEARED  8'h04
`define GPC_OFF_TARGET  8'h08
`define GPC_OFF_CEIL    8'h0c
`define GPC_OFF_MULT    8'h10
`define GPC_OFF_DIV     8'h14
`define GPC_OFF_CTRL    8'h18
`define GPC_OFF_CNT2    8'h1c
`define GPC_OFF_STAT    8'h20
`define GPC_OFF_MASK    8'h24
`define GPC_LAST_IDX    6'h09

// ****************************************
// Reset values
// ****************************************
`define GPC_RST_TARGET  32'h000003e8
`define GPC_RST_CEIL    32'hffffffff
`define GPC_RST_MULT    16'h0001
`define GPC_RST_DIV     16'h0001
`define GPC_RST_CTRL    9'h001
`define GPC_RST_MASK    3'h0
`define GPC_RST_STAT    3'h0

// ****************************************
// Timing counts
// ****************************************
`define GPC_GEAR_STEPS  6'd48
`define GPC_BLANK_PASS  2'h2

// ****************************************
// Control fields
// ****************************************
`define GPC_CTRL_METHOD 0
`define GPC_CTRL_ACT_LO 4
`define GPC_CTRL_ACT_HI 5
`define GPC_CTRL_KEEP   8
`define GPC_CTRL_WMASK  9'h131

// ****************************************
// Status bits
// ****************************************
`define GPC_ST_TARGET   0
`define GPC_ST_CEIL     1
`define GPC_ST_CNT2     2

// ****************************************
// Bus responses
// ****************************************
`define GPC_RESP_OKAY   2'h0
`define GPC_RESP_SLVERR 2'h2

`endif

// ===== rtl/gpc_edge_cnt.v
// Edge counter: counts rising edges of a synchronous input.
// Assumes the input is already synchronous to clk_i.
`timescale 1ns/1ps
module gpc_edge_cnt #(
  parameter W = 32
) (
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire         pulse_i,
  input  wire         clear_i,
  input  wire         hold_i,
  output reg  [W-1:0] count_o,
  output wire         wrap_o
);
  reg pulse_d_reg;
  wire rise;

  assign rise   = pulse_i & ~pulse_d_reg;
  assign wrap_o = rise & ~clear_i & ~hold_i & (&count_o);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_d_reg <= 1'b0;
      count_o     <= {W{1'b0}};
    end else begin
      pulse_d_reg <= pulse_i;
      if (clear_i) begin
        count_o <= {W{1'b0}};
      end else if (rise && !hold_i) begin
        count_o <= count_o + 1'b1;
      end
    end
  end
endmodule

// ===== rtl/gpc_gear.v
// Electronic gear: raw total times numerator over denominator.
// Assumes numerator and denominator never zero; recomputes continuously.
`timescale 1ns/1ps
`include "gpc_defines.vh"
module gpc_gear (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire [31:0] raw_i,
  input  wire [15:0] mult_i,
  input  wire [15:0] div_i,
  output reg  [31:0] geared_o,
  output reg         done_o
);
  // ****************************************
  // Restoring divider, one quotient bit per cycle
  // ****************************************
  reg [47:0] quot_reg;
  reg [16:0] rem_reg;
  reg [15:0] div_reg;
  reg [5:0]  step_reg;
  wire [16:0] trial;

  assign trial = {rem_reg[15:0], quot_reg[47]} - {1'b0, div_reg};

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quot_reg <= 48'h0;
      rem_reg  <= 17'h0;
      div_reg  <= 16'h1;
      step_reg <= 6'h0;
      geared_o <= 32'h0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (step_reg == 6'h0) begin
        // Operands are sampled here so a mid-run change cannot corrupt it
        quot_reg <= raw_i * mult_i;
        div_reg  <= div_i;
        rem_reg  <= 17'h0;
        step_reg <= `GPC_GEAR_STEPS;
      end else begin
        if (!trial[16]) begin
          rem_reg  <= trial;
          quot_reg <= {quot_reg[46:0], 1'b1};
        end else begin
          rem_reg  <= {rem_reg[15:0], quot_reg[47]};
          quot_reg <= {quot_reg[46:0], 1'b0};
        end
        step_reg <= step_reg - 6'h1;
        if (step_reg == 6'h1) begin
          done_o <= 1'b1;
          // Remainder is dropped; a quotient past 32 bits saturates
          if (|quot_reg[46:31]) begin
            geared_o <= 32'hffffffff;
          end else begin
            geared_o <= {quot_reg[30:0], ~trial[16]};
          end
        end
      end
    end
  end
endmodule

// ===== testbench/gpc_top_monitor.sv
// Checker of the geared pulse counter: bus handshakes and output relations.
// Assumes it is bound to gpc_top and sees only its ports.
`timescale 1ns/1ps
module gpc_top_monitor (
  input wire        clk_i,
  input wire        reset_n_i,
  input wire        counter_reset_i,
  input wire        target_reached_o,
  input wire [1:0]  stop_action_o,
  input wire        irq_o,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  // ****************
  // Clear terminal hold time
  // ****************
  // Saturates so a long hold never wraps back below the limit
  logic [7:0] clr_reg;
  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) clr_reg <= 8'h00;
    else if (!counter_reset_i) clr_reg <= 8'h00;
    else if (clr_reg != 8'hff) clr_reg <= clr_reg + 8'h01;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("illegal write response");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  act_idle_a: assert property (!target_reached_o |-> stop_action_o == 2'h0)
    else $error("stop action without target");
  clr_hold_a: assert property (clr_reg >= 8'h78 |-> !target_reached_o)
    else $error("target flag survives clear");

  cover property ($rose(target_reached_o));
  cover property ($rose(irq_o));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// ===== testbench/gpc_pulse_src.sv
// Field pulse source feeding both counter terminals.
// Assumes one burst is asked for at a time and that busy_o is awaited.
`timescale 1ns/1ps
module gpc_pulse_src (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire [7:0] num_i,
  input  wire       sel_i,
  input  wire [7:0] gap_i,
  output reg        in1_o,
  output reg        in2_o,
  output reg        busy_o
);
  // ****************
  // Burst generator
  // ****************
  // A gap of 100 or more keeps each pulse clear of the gear pass
  initial begin
    in1_o = 1'b0;
    in2_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (num_i) begin
          if (sel_i) in2_o <= 1'b1;
          else in1_o <= 1'b1;
          repeat (3) @(posedge clk_i);
          in1_o <= 1'b0;
          in2_o <= 1'b0;
          repeat (gap_i) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// ===== testbench/test_geared_pulse_counter.sv
// Bench of the geared pulse counter: registers, gear, target, ceiling, clear.
// Assumes the pulse source model and the checker are compiled first.
`timescale 1ns/1ps
`include "gpc_defines.vh"
module test_geared_pulse_counter;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        counter_reset_i = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, src_num = 8'h00, src_gap = 8'h64;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, src_go = 1'b0, src_sel = 1'b0;
  wire         counter_in_i, counter2_in_i, target_reached_o, retain_count_o, irq_o;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_busy;
  wire [1:0]   stop_action_o, s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  logic [33:0] bq[$], rq[$];
  int          failures = 0, checks = 0, seed = 32'h9b65;
  logic [31:0] rst_val [10] = '{32'h0, 32'h0, 32'h3e8, 32'hffffffff, 32'h1, 32'h1,
                                32'h1, 32'h0, 32'h0, 32'h0};

  gpc_top dut (.clk_i, .reset_n_i, .counter_in_i, .counter_reset_i, .counter2_in_i,
    .target_reached_o, .stop_action_o, .retain_count_o, .irq_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  gpc_pulse_src src (.clk_i, .go_i(src_go), .num_i(src_num), .sel_i(src_sel),
    .gap_i(src_gap), .in1_o(counter_in_i), .in2_o(counter2_in_i), .busy_o(src_busy));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ****************
  // Checking and closing
  // ****************
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rdata, s_axi_rresp}, rq.pop_front());
  end

  // ****************
  // Bus and terminal drivers
  // ****************
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
    bq.push_back({32'h0, r});
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
    rq.push_back({d, r});
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input [7:0] n, input s);
    @(posedge clk_i);
    src_num <= n;
    src_sel <= s;
    src_gap <= 8'h64 + 8'($random(seed) & 32'h1f);
    src_go <= 1'b1;
    @(posedge clk_i);
    src_go <= 1'b0;
    do @(posedge clk_i); while (src_busy);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    logic [31:0] m, dv, n, g, t, act;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i << 2), rst_val[i]);
    rd(8'h28, 32'h0, 2'h2);
    wr(8'h28, 32'h1, 2'h2);
    chk(34'(retain_count_o), 34'h0);
    $display("test reset values done");
    m = ($random(seed) & 32'h7) + 32'h1;
    dv = ($random(seed) & 32'h7) + 32'h1;
    n = ($random(seed) & 32'h3) + 32'h2;
    act = $random(seed) & 32'h3;
    g = n * m / dv;
    t = (g == 32'h0) ? 32'h1 : g + ($random(seed) & 32'h1);
    wr(`GPC_OFF_MULT, m);
    wr(`GPC_OFF_DIV, dv);
    wr(`GPC_OFF_DIV, 32'h0);
    wr(`GPC_OFF_TARGET, t);
    wr(`GPC_OFF_CTRL, 32'h100 | (act << 4));
    wr(`GPC_OFF_MASK, 32'h1);
    pulse(n[7:0], 1'b0);
    repeat (200) @(posedge clk_i);
    rd(`GPC_OFF_RAW, n);
    rd(`GPC_OFF_GEARED, g);
    rd(`GPC_OFF_DIV, dv);
    wr(`GPC_OFF_GEARED, 32'h5);
    rd(`GPC_OFF_GEARED, g);
    chk(34'(target_reached_o), 34'(g >= t));
    chk(34'(stop_action_o), (g >= t) ? 34'(act) : 34'h0);
    chk(34'(retain_count_o), 34'h1);
    chk(34'(irq_o), 34'(g >= t));
    wr(`GPC_OFF_STAT, 32'h7);
    @(posedge clk_i);
    chk(34'(irq_o), 34'h0);
    $display("test gear and target done");
    counter_reset_i <= 1'b1;
    pulse(8'h1, 1'b0);
    repeat (60) @(posedge clk_i);
    rd(`GPC_OFF_RAW, 32'h0);
    rd(`GPC_OFF_GEARED, 32'h0);
    counter_reset_i <= 1'b0;
    $display("test clear terminal done");
    wr(`GPC_OFF_MULT, 32'h1);
    wr(`GPC_OFF_DIV, 32'h1);
    wr(`GPC_OFF_TARGET, 32'h3e8);
    wr(`GPC_OFF_CEIL, 32'h3);
    wr(`GPC_OFF_CTRL, 32'h0);
    wr(`GPC_OFF_STAT, 32'h7);
    wr(`GPC_OFF_MASK, 32'h2);
    pulse(8'h5, 1'b0);
    repeat (200) @(posedge clk_i);
    rd(`GPC_OFF_RAW, 32'h3);
    rd(`GPC_OFF_GEARED, 32'h3);
    rd(`GPC_OFF_STAT, 32'h2);
    chk(34'(irq_o), 34'h1);
    counter_reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    counter_reset_i <= 1'b0;
    wr(`GPC_OFF_CTRL, 32'h1);
    pulse(8'h3, 1'b0);
    repeat (300) @(posedge clk_i);
    rd(`GPC_OFF_RAW, 32'h0);
    rd(`GPC_OFF_GEARED, 32'h0);
    $display("test ceiling done");
    pulse(8'h3, 1'b1);
    rd(`GPC_OFF_CNT2, 32'h3);
    $display("test second counter done");
    s_axi_wstrb <= 4'h1;
    wr(`GPC_OFF_TARGET, 32'hffffff22);
    s_axi_wstrb <= 4'hf;
    rd(`GPC_OFF_TARGET, 32'h322);
    $display("test byte lanes done");
    complete_run();
  end
endmodule

bind gpc_top gpc_top_monitor mon (.clk_i, .reset_n_i, .counter_reset_i, .target_reached_o,
  .stop_action_o, .irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
